// [hdl/cpd_top.sv]
// Coil PWM driver top: APB registers, input synchronisers and PWM outputs.
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
module cpd_top import cpd_pkg::*; #(
    parameter int unsigned PULL_IN_CYCLES = 32'(CPD_PULL_IN_CYC)
) (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_nrst,
    // APB slave.
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Activation pins.
    input wire logic i_contactor_act,
    input wire logic i_brake_release,
    // Coil and valve drives.
    output logic [CPD_NUM_VALVES-1:0] o_valve_pwm,
    output logic o_contactor_pwm,
    output logic o_brake_pwm
);
    // Register file.
    logic [7:0] valve_q [CPD_NUM_VALVES];
    logic [7:0] valve_d [CPD_NUM_VALVES];
    cpd_coil_cfg_s con_cfg_q, con_cfg_d;
    cpd_coil_cfg_s brk_cfg_q, brk_cfg_d;
    logic [31:0] prdata_q, prdata_d;

    // Bus decode.
    logic wr_en;
    logic setup;
    logic mapped;
    logic [31:0] rd_mux;
    logic [6:0] wr_pct;

    // Synchronised activation levels.
    logic [1:0] pin_raw;
    logic [1:0] s1_q, s2_q, s3_q, lvl_q;
    logic [1:0] s1_d, s2_d, s3_d, lvl_d;

    // Coil profiles.
    logic [6:0] con_duty, brk_duty;
    cpd_phase_e con_phase, brk_phase;
    logic [31:0] status;

    function automatic logic [6:0] clamp_pct(input logic [31:0] v);
        clamp_pct = (v > 32'(CPD_PCT_MAX)) ? CPD_PCT_MAX : v[6:0];
    endfunction

    assign o_pready = 1'b1;
    assign setup = i_psel && !i_penable;
    assign wr_en = i_psel && i_penable && i_pwrite;
    assign wr_pct = clamp_pct(i_pwdata);

    always_comb begin
        mapped = (i_paddr == CPD_OFF_CON_PULL) || (i_paddr == CPD_OFF_CON_HOLD)
            || (i_paddr == CPD_OFF_BRK_PULL) || (i_paddr == CPD_OFF_BRK_HOLD)
            || (i_paddr == CPD_OFF_STATUS);
        for (int k = 0; k < CPD_NUM_VALVES; k++) begin
            if (i_paddr == CPD_OFF_VALVE[k]) begin
                mapped = 1'b1;
            end
        end
    end

    assign o_pslverr = i_psel && i_penable && !mapped;

    // Pin synchronisers: a change counts once the second and third stages agree.
    assign pin_raw = {i_brake_release, i_contactor_act};

    always_comb begin
        s1_d = pin_raw;
        s2_d = s1_q;
        s3_d = s2_q;
        lvl_d = lvl_q;
        for (int k = 0; k < 2; k++) begin
            if (s2_q[k] == s3_q[k]) begin
                lvl_d[k] = s3_q[k];
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            s1_q <= 2'h0;
            s2_q <= 2'h0;
            s3_q <= 2'h0;
            lvl_q <= 2'h0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            lvl_q <= lvl_d;
        end
    end

    // Register writes; percent settings above 100 are clamped to 100.
    always_comb begin
        valve_d = valve_q;
        con_cfg_d = con_cfg_q;
        brk_cfg_d = brk_cfg_q;
        if (wr_en) begin
            for (int k = 0; k < CPD_NUM_VALVES; k++) begin
                if (i_paddr == CPD_OFF_VALVE[k]) begin
                    valve_d[k] = i_pwdata[7:0];
                end
            end
            if (i_paddr == CPD_OFF_CON_PULL) begin
                con_cfg_d.pull_in = wr_pct;
            end
            if (i_paddr == CPD_OFF_CON_HOLD) begin
                con_cfg_d.hold_pct = wr_pct;
            end
            if (i_paddr == CPD_OFF_BRK_PULL) begin
                brk_cfg_d.pull_in = wr_pct;
            end
            if (i_paddr == CPD_OFF_BRK_HOLD) begin
                brk_cfg_d.hold_pct = wr_pct;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            for (int k = 0; k < CPD_NUM_VALVES; k++) begin
                valve_q[k] <= CPD_RST_VALVE;
            end
            con_cfg_q <= '{pull_in: CPD_RST_PULL, hold_pct: CPD_RST_HOLD};
            brk_cfg_q <= '{pull_in: CPD_RST_PULL, hold_pct: CPD_RST_HOLD};
        end else begin
            valve_q <= valve_d;
            con_cfg_q <= con_cfg_d;
            brk_cfg_q <= brk_cfg_d;
        end
    end

    // Status word shows the live coil state.
    always_comb begin
        status = 32'h0;
        status[CPD_ST_CON_ACT] = lvl_q[0];
        status[CPD_ST_BRK_ACT] = lvl_q[1];
        status[CPD_ST_CON_PH +: 2] = con_phase;
        status[CPD_ST_BRK_PH +: 2] = brk_phase;
        status[CPD_ST_CON_DUTY +: 7] = con_duty;
        status[CPD_ST_BRK_DUTY +: 7] = brk_duty;
    end

    // Read data is captured in the setup cycle so it is stable in the access cycle.
    always_comb begin
        rd_mux = 32'h0;
        for (int k = 0; k < CPD_NUM_VALVES; k++) begin
            if (i_paddr == CPD_OFF_VALVE[k]) begin
                rd_mux = {24'h0, valve_q[k]};
            end
        end
        case (i_paddr)
            CPD_OFF_CON_PULL: rd_mux = {25'h0, con_cfg_q.pull_in};
            CPD_OFF_CON_HOLD: rd_mux = {25'h0, con_cfg_q.hold_pct};
            CPD_OFF_BRK_PULL: rd_mux = {25'h0, brk_cfg_q.pull_in};
            CPD_OFF_BRK_HOLD: rd_mux = {25'h0, brk_cfg_q.hold_pct};
            CPD_OFF_STATUS: rd_mux = status;
            default: rd_mux = rd_mux;
        endcase
        prdata_d = (setup && !i_pwrite) ? rd_mux : prdata_q;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            prdata_q <= 32'h0;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    assign o_prdata = prdata_q;

    // Valve channels.
    for (genvar g = 0; g < CPD_NUM_VALVES; g++) begin : g_valve
        cpd_pwm_chan #(.W(8), .PERIOD(CPD_VALVE_PERIOD)) u_chan (
            .i_mclk(i_mclk),
            .i_nrst(i_nrst),
            .i_duty(valve_q[g]),
            .i_off(1'b0),
            .o_pwm(o_valve_pwm[g])
        );
    end

    // Contactor coil.
    cpd_coil_prof #(.PULL_CYCLES(PULL_IN_CYCLES)) u_con_prof (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_active(lvl_q[0]),
        .i_cfg(con_cfg_q),
        .o_duty(con_duty),
        .o_phase(con_phase)
    );

    cpd_pwm_chan #(.W(7), .PERIOD(CPD_COIL_PERIOD)) u_con_pwm (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_duty(con_duty),
        .i_off(con_phase == CPD_IDLE),
        .o_pwm(o_contactor_pwm)
    );

    // Brake coil.
    cpd_coil_prof #(.PULL_CYCLES(PULL_IN_CYCLES)) u_brk_prof (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_active(lvl_q[1]),
        .i_cfg(brk_cfg_q),
        .o_duty(brk_duty),
        .o_phase(brk_phase)
    );

    cpd_pwm_chan #(.W(7), .PERIOD(CPD_COIL_PERIOD)) u_brk_pwm (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_duty(brk_duty),
        .i_off(brk_phase == CPD_IDLE),
        .o_pwm(o_brake_pwm)
    );

    valve_write_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (wr_en && i_paddr == CPD_OFF_VALVE[0]) |=> (valve_q[0] == $past(i_pwdata[7:0])))
        else $error("valve duty write lost");
    pct_clamp_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (wr_en && i_paddr == CPD_OFF_CON_PULL)
        |=> (con_cfg_q.pull_in == clamp_pct($past(i_pwdata))))
        else $error("pull-in duty write wrong");
    coil_off_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (con_phase == CPD_IDLE) [*2] |-> !o_contactor_pwm)
        else $error("contactor driven while idle");
    unmapped_err_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_psel && i_penable && i_paddr > CPD_OFF_STATUS) |-> o_pslverr)
        else $error("unmapped access not flagged");
    unmapped_wr_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (wr_en && !mapped) |=> ($stable(con_cfg_q) && $stable(brk_cfg_q)))
        else $error("unmapped write changed a setting");
    valve_last_write_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (wr_en && i_paddr == CPD_OFF_VALVE[CPD_NUM_VALVES-1])
        |=> (valve_q[CPD_NUM_VALVES-1] == $past(i_pwdata[7:0])))
        else $error("last valve duty write lost");
    hold_write_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (wr_en && i_paddr == CPD_OFF_CON_HOLD)
        |=> (con_cfg_q.hold_pct == clamp_pct($past(i_pwdata))))
        else $error("contactor hold write wrong");
    brk_pull_write_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (wr_en && i_paddr == CPD_OFF_BRK_PULL)
        |=> (brk_cfg_q.pull_in == clamp_pct($past(i_pwdata))))
        else $error("brake pull-in write wrong");
    brk_hold_write_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (wr_en && i_paddr == CPD_OFF_BRK_HOLD)
        |=> (brk_cfg_q.hold_pct == clamp_pct($past(i_pwdata))))
        else $error("brake hold write wrong");
    pct_range_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (con_cfg_q.pull_in <= CPD_PCT_MAX) && (con_cfg_q.hold_pct <= CPD_PCT_MAX)
        && (brk_cfg_q.pull_in <= CPD_PCT_MAX) && (brk_cfg_q.hold_pct <= CPD_PCT_MAX))
        else $error("percent setting above full scale");
    brake_off_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (brk_phase == CPD_IDLE) [*2] |-> !o_brake_pwm)
        else $error("brake driven while idle");

    // Bus protocol: no wait states, error only in access, read data held between reads.
    ready_high_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_psel |-> o_pready)
        else $error("ready low during a transfer");
    err_setup_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        setup |-> !o_pslverr)
        else $error("error flagged in setup cycle");
    rdata_hold_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        !(setup && !i_pwrite) |=> $stable(o_prdata))
        else $error("read data moved outside a read");
    rdata_load_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (setup && !i_pwrite) |=> (o_prdata == $past(rd_mux)))
        else $error("read data not captured in setup");

    // Activation synchronisers: the level moves only when stages two and three agree.
    con_sync_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (s2_q[0] != s3_q[0]) |=> $stable(lvl_q[0]))
        else $error("contactor level moved on a glitch");
    brk_sync_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (s2_q[1] != s3_q[1]) |=> $stable(lvl_q[1]))
        else $error("brake level moved on a glitch");
    con_level_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (s2_q[0] == s3_q[0]) |=> (lvl_q[0] == $past(s3_q[0])))
        else $error("contactor level not taken");
    brk_level_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (s2_q[1] == s3_q[1]) |=> (lvl_q[1] == $past(s3_q[1])))
        else $error("brake level not taken");
endmodule

// [pkg/cpd_pkg.sv]
// Constants, types and register map of the coil PWM driver.
package cpd_pkg;

    // Clock rate and pull-in phase length.
    localparam longint CPD_CLK_HZ = 100_000_000;
    localparam longint CPD_PULL_IN_MS = 1000;
    localparam longint CPD_PULL_IN_CYC = (CPD_PULL_IN_MS * CPD_CLK_HZ + 999) / 1000;

    // PWM periods in clock cycles and number of valves.
    localparam int CPD_VALVE_PERIOD = 255;
    localparam int CPD_COIL_PERIOD = 100;
    localparam int CPD_NUM_VALVES = 5;

    // Percent scale.
    localparam logic [6:0] CPD_PCT_MAX = 7'h64;
    localparam logic [13:0] CPD_PCT_DIV = 14'h0064;

    // Register byte offsets.
    localparam logic [7:0] CPD_OFF_VALVE [CPD_NUM_VALVES] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    localparam logic [7:0] CPD_OFF_CON_PULL = 8'h14;
    localparam logic [7:0] CPD_OFF_CON_HOLD = 8'h18;
    localparam logic [7:0] CPD_OFF_BRK_PULL = 8'h1c;
    localparam logic [7:0] CPD_OFF_BRK_HOLD = 8'h20;
    localparam logic [7:0] CPD_OFF_STATUS = 8'h24;

    // Values after reset.
    localparam logic [7:0] CPD_RST_VALVE = 8'h00;
    localparam logic [6:0] CPD_RST_PULL = 7'h64;
    localparam logic [6:0] CPD_RST_HOLD = 7'h64;

    // Status field positions.
    localparam int CPD_ST_CON_ACT = 0;
    localparam int CPD_ST_BRK_ACT = 1;
    localparam int CPD_ST_CON_PH = 2;
    localparam int CPD_ST_BRK_PH = 4;
    localparam int CPD_ST_CON_DUTY = 8;
    localparam int CPD_ST_BRK_DUTY = 16;

    typedef enum logic [1:0] {
        CPD_IDLE = 2'b00,
        CPD_PULL = 2'b01,
        CPD_HOLD = 2'b10
    } cpd_phase_e;

    typedef struct packed {
        logic [6:0] pull_in;
        logic [6:0] hold_pct;
    } cpd_coil_cfg_s;

endpackage

// [hdl/cpd_pwm_chan.sv]
// One PWM channel with a fixed period and a duty taken at each period start.
`timescale 1ns/1ps
module cpd_pwm_chan import cpd_pkg::*; #(
    parameter int W = 8,
    parameter int PERIOD = 255
) (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Duty in counts and immediate shut-off.
    input wire logic [W-1:0] i_duty,
    input wire logic i_off,
    // PWM output.
    output logic o_pwm
);
    localparam logic [W-1:0] LAST = W'(PERIOD - 1);

    logic [W-1:0] cnt_q, cnt_d;
    logic [W-1:0] duty_q, duty_d;
    logic pwm_q, pwm_d;

    // The duty is only taken at a wrap so a period is never cut short.
    always_comb begin
        cnt_d = (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
        duty_d = (cnt_q == LAST) ? i_duty : duty_q;
        pwm_d = !i_off && (cnt_q < duty_q);
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            cnt_q <= '0;
            duty_q <= '0;
            pwm_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            duty_q <= duty_d;
            pwm_q <= pwm_d;
        end
    end

    assign o_pwm = pwm_q;

    pwm_high_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (!i_off && cnt_q < duty_q) |=> o_pwm)
        else $error("pwm low inside on time");
    pwm_low_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_off || cnt_q >= duty_q) |=> !o_pwm)
        else $error("pwm high outside on time");
    pwm_wrap_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (cnt_q == LAST) |=> (cnt_q == '0) && (duty_q == $past(i_duty)))
        else $error("pwm period or duty load wrong");
endmodule

// [hdl/cpd_coil_prof.sv]
// Pull-in then hold duty profile for one coil.
`timescale 1ns/1ps
module cpd_coil_prof import cpd_pkg::*; #(
    parameter int unsigned PULL_CYCLES = 100
) (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Activation level and settings.
    input wire logic i_active,
    input cpd_coil_cfg_s i_cfg,
    // Duty in percent and phase.
    output logic [6:0] o_duty,
    output cpd_phase_e o_phase
);
    localparam logic [31:0] LAST = 32'(PULL_CYCLES - 1);

    cpd_phase_e state_q, state_d;
    logic [31:0] cnt_q, cnt_d;
    logic [6:0] duty_q, duty_d;
    logic [13:0] prod;
    logic [6:0] hold_duty;

    assign prod = i_cfg.pull_in * i_cfg.hold_pct;
    assign hold_duty = 7'(prod / CPD_PCT_DIV);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            CPD_IDLE: begin
                if (i_active) begin
                    state_d = CPD_PULL;
                    cnt_d = '0;
                end
            end
            CPD_PULL: begin
                if (!i_active) begin
                    state_d = CPD_IDLE;
                end else if (cnt_q == LAST) begin
                    state_d = CPD_HOLD;
                end else begin
                    cnt_d = cnt_q + 32'h1;
                end
            end
            CPD_HOLD: begin
                if (!i_active) begin
                    state_d = CPD_IDLE;
                end
            end
            default: begin
                state_d = CPD_IDLE;
            end
        endcase
        case (state_d)
            CPD_PULL: duty_d = i_cfg.pull_in;
            CPD_HOLD: duty_d = hold_duty;
            default: duty_d = 7'h00;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            state_q <= CPD_IDLE;
            cnt_q <= '0;
            duty_q <= 7'h00;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            duty_q <= duty_d;
        end
    end

    assign o_duty = duty_q;
    assign o_phase = state_q;

    prof_start_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (state_q == CPD_IDLE && i_active) |=> (state_q == CPD_PULL && cnt_q == '0))
        else $error("pull-in phase did not start");
    prof_count_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (state_q == CPD_PULL && i_active && cnt_q != LAST)
        |=> (state_q == CPD_PULL && cnt_q == $past(cnt_q) + 32'h1))
        else $error("pull-in phase ended early");
    prof_hold_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (state_q == CPD_PULL && i_active && cnt_q == LAST) |=> (state_q == CPD_HOLD))
        else $error("hold phase not entered");
    prof_duty_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (state_q == CPD_HOLD && i_active) |=> (o_duty == $past(hold_duty)))
        else $error("hold duty wrong");
    prof_off_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        !i_active |=> (state_q == CPD_IDLE && o_duty == 7'h00))
        else $error("coil not off after release");
endmodule

// [verif/cpd_coil_model.sv]
// Coil load model that counts the cycles its drive line is high.
`timescale 1ns/1ps
module cpd_coil_model (
    // Clock and count restart.
    input wire logic i_mclk,
    input wire logic i_clr,
    // Coil drive.
    input wire logic i_pwm,
    // High cycles since the last restart.
    output logic [15:0] o_high
);
    logic [15:0] high_d;

    always_comb begin
        high_d = o_high + 16'(i_pwm);
        if (i_clr) begin
            high_d = 16'h0000;
        end
    end

    always_ff @(posedge i_mclk) begin
        o_high <= high_d;
    end
endmodule

// [verif/coil_pwm_driver_tb_top.sv]
// Self-checking bench for the coil PWM driver.
`timescale 1ns/1ps
module coil_pwm_driver_tb_top import cpd_pkg::*; ;
    localparam int N = 400;
    logic mclk, nrst, psel, penable, pwrite, pready, pslverr;
    logic con_act, brk_rel, cpwm, bpwm, clr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [4:0] vpwm;
    logic [6:0] pw;
    logic [15:0] hi [7];
    int miscompares, samples_checked;

    cpd_top #(.PULL_IN_CYCLES(N)) dut (.i_mclk(mclk), .i_nrst(nrst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_contactor_act(con_act), .i_brake_release(brk_rel), .o_valve_pwm(vpwm),
        .o_contactor_pwm(cpwm), .o_brake_pwm(bpwm));

    assign pw = {bpwm, cpwm, vpwm};
    for (genvar g = 0; g < 7; g++) begin : g_coil
        cpd_coil_model u_coil (.i_mclk(mclk), .i_clr(clr), .i_pwm(pw[g]), .o_high(hi[g]));
    end

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        rd = prdata;
        err = pslverr;
        chk(32'(n < 100), 32'h1, "no ready");
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk(32'(e), 32'h0, "write error");
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp, msg);
        chk(32'(e), 32'h0, "read error");
    endtask

    // Restarts every load counter and lets one window of cycles pass.
    // The count is read one edge late, before that edge's own update lands.
    task automatic window(input int per);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        repeat (per + 1) @(posedge mclk);
    endtask

    task automatic stat(input int ph, input int du, input logic [1:0] p, input logic [6:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b0, CPD_OFF_STATUS, 32'h0, r, e);
        chk(32'(r[ph +: 2]), 32'(p), "phase");
        chk(32'(r[du +: 7]), 32'(d), "applied duty");
    endtask

    task automatic t_regs();
        logic [31:0] r;
        logic e;
        for (int i = 0; i < CPD_NUM_VALVES; i++) begin
            rdchk(CPD_OFF_VALVE[i], 32'(CPD_RST_VALVE), "valve reset");
        end
        rdchk(CPD_OFF_CON_PULL, 32'(CPD_RST_PULL), "pull reset");
        rdchk(CPD_OFF_BRK_HOLD, 32'(CPD_RST_HOLD), "hold reset");
        wr(CPD_OFF_CON_HOLD, 32'h7f);
        rdchk(CPD_OFF_CON_HOLD, 32'(CPD_PCT_MAX), "clamp");
        apb(1'b0, 8'h28, 32'h0, r, e);
        chk(r, 32'h0, "unmapped data");
        chk(32'(e), 32'h1, "unmapped error");
        apb(1'b1, 8'h28, 32'h55, r, e);
        chk(32'(e), 32'h1, "unmapped write error");
        $display("register test done");
    endtask

    task automatic t_valves();
        logic [7:0] d [5] = '{8'h00, 8'h01, 8'h80, 8'hfe, 8'hff};
        for (int i = 0; i < 5; i++) begin
            wr(CPD_OFF_VALVE[i], 32'(d[i]));
            rdchk(CPD_OFF_VALVE[i], 32'(d[i]), "valve readback");
        end
        repeat (260) @(posedge mclk);
        window(CPD_VALVE_PERIOD);
        for (int i = 0; i < 5; i++) begin
            chk(32'(hi[i]), 32'(d[i]), "valve duty");
        end
        $display("valve test done");
    endtask

    // Second pass re-arms the coil after it was dropped.
    task automatic t_coil(input int b, input logic [6:0] pull, input logic [6:0] hold,
                          input logic [6:0] hduty);
        int ph;
        int du;
        ph = b ? CPD_ST_BRK_PH : CPD_ST_CON_PH;
        du = b ? CPD_ST_BRK_DUTY : CPD_ST_CON_DUTY;
        wr(b ? CPD_OFF_BRK_PULL : CPD_OFF_CON_PULL, 32'(pull));
        wr(b ? CPD_OFF_BRK_HOLD : CPD_OFF_CON_HOLD, 32'(hold));
        repeat (2) begin
            if (b) brk_rel <= 1'b1;
            else con_act <= 1'b1;
            repeat (110) @(posedge mclk);
            window(CPD_COIL_PERIOD);
            chk(32'(hi[5 + b]), 32'(pull), "pull duty");
            stat(ph, du, CPD_PULL, pull);
            repeat (300) @(posedge mclk);
            window(CPD_COIL_PERIOD);
            chk(32'(hi[5 + b]), 32'(hduty), "hold duty");
            stat(ph, du, CPD_HOLD, hduty);
            if (b) brk_rel <= 1'b0;
            else con_act <= 1'b0;
            repeat (10) @(posedge mclk);
            window(CPD_COIL_PERIOD);
            chk(32'(hi[5 + b]), 32'h0, "coil off");
        end
        $display("coil test done");
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        miscompares = 0;
        samples_checked = 0;
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        con_act = 1'b0;
        brk_rel = 1'b0;
        clr = 1'b0;
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        t_regs();
        t_valves();
        t_coil(0, 7'h46, 7'h46, 7'h31);
        t_coil(1, 7'h64, 7'h46, 7'h46);
        t_coil(1, 7'h46, 7'h64, 7'h46);
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        give_verdict();
    end
endmodule
